/* core/gyps_core.sv */
// Behaviour
// - After power-up: normal mode, everything powered, continuous sampling.
// - Lowest-power request bit 1 enters lowest-power mode, 0 leaves it.
// - Lowest-power: only interface alive, no sampling, configuration lost.
// - Lowest-power: request, three-wire and watchdog bits stay functional.
// - Lowest-power: interrupt pin level and open-drain bits stay accessible.
// - Soft-reset write in lowest-power mode returns to normal mode.
// - Analog-off: analog down, no sampling, data and configuration kept.
// - Analog-off: only register reads, soft-reset and power-mode control writes supported.
// - Analog-off request 1 with fast-wake select 0 enters analog-off.
// - Two-bit wake source field wakes either low-power mode from a pin.
// - Fast-wake: sensing and acquisition off, drive on, data kept.
// - Analog-off request 1 with fast-wake select 1 enters fast-wake.
// - Power-save enable cycles between normal and fast-wake mode.
// - Fast-wake dwell code 0..7 gives 2,4,5,8,10,15,18,20 ms.
// - Awake dwell code 1..7 gives 4,5,8,10,15,20,40 ms; 0 unused.
// - Rate data: six bytes, three 16-bit two's complement axes.
// - Lower byte read locks the upper byte unless shadow-disable set.
// - Burst read address increments, then sticks at buffer port.
// - Rate registers frozen while a burst read is active.
// - Unfiltered select shows unfiltered data, else filtered data.
`timescale 1ns/100ps
`include "gyps_params.svh"

module gyps_link (
    input  wire logic                     linkClk,
    input  wire logic                     reset,
    input  wire logic                     chipSelectN,
    input  wire logic                     serialIn,
    input  wire gyps_pkg::gyps_image_type regImage,
    output logic                          serialOut,
    output logic                          serialOutEn,
    output gyps_pkg::gyps_xfer_type       xfer
);
    import gyps_pkg::*;

    gyps_link_type q;
    gyps_link_type d;
    gyps_xfer_type xd;
    logic [7:0]    rxByte;
    logic [6:0]    cur;
    logic [6:0]    nxt;
    logic          rd;

    // ------------------------------------------------------------------
    // Read map
    // ------------------------------------------------------------------
    function automatic logic [7:0] readByte(input logic [6:0] a, input gyps_image_type im);
        logic [6:0] r;
        r = a - `GYPS_ADR_RATE0;
        case (a)
            `GYPS_ADR_BW:  readByte = im.bw;
            `GYPS_ADR_PMC: readByte = im.pmc;
            `GYPS_ADR_PSC: readByte = im.psc;
            `GYPS_ADR_RO:  readByte = im.ro;
            `GYPS_ADR_IE:  readByte = im.ie;
            `GYPS_ADR_IF:  readByte = im.ifc;
            default: begin
                if (r < `GYPS_RATE_BYTES) begin
                    readByte = r[0] ? im.rate[r[2:1]][15:8] : im.rate[r[2:1]][7:0];
                end else begin
                    readByte = 8'h00;
                end
            end
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Byte assembly and address walk
    // ------------------------------------------------------------------
    always_comb begin
        d        = q;
        xd       = xfer;
        rxByte   = {q.shIn, serialIn};
        cur      = q.first ? rxByte[6:0] : q.addr;
        rd       = q.first ? rxByte[7] : q.isRead;
        nxt      = (cur == `GYPS_ADR_BUF) ? cur : cur + 7'h01;
        d.bitCnt = q.bitCnt + 3'h1;
        d.shIn   = {q.shIn[5:0], serialIn};
        d.shOut  = {q.shOut[6:0], 1'b0};
        // A loaded byte counts as read only once its first bit is clocked out
        if (q.bitCnt == 3'h0 && q.isRead && !q.first) xd.rdTog = ~xfer.rdTog;
        if (q.bitCnt == 3'h7) begin
            d.first  = 1'b0;
            d.isRead = rd;
            d.addr   = cur;
            if (rd) begin
                d.shOut   = readByte(cur, regImage);
                d.addr    = nxt;
                xd.rdAddr = cur;
            end else if (!q.first) begin
                d.addr    = nxt;
                xd.wrAddr = cur;
                xd.wrData = rxByte;
                xd.wrTog  = ~xfer.wrTog;
            end
        end
    end

    always_ff @(posedge linkClk or posedge chipSelectN) begin
        if (chipSelectN) begin
            q        <= '0;
            q.first  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Toggles must survive between frames, so only the system reset clears them
    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) begin
            xfer <= '0;
        end else begin
            xfer <= xd;
        end
    end

    // Data launched on the falling edge, sampled by the host on the rising edge
    always_ff @(negedge linkClk or posedge chipSelectN) begin
        if (chipSelectN) begin
            serialOut   <= 1'b0;
            serialOutEn <= 1'b0;
        end else begin
            serialOut   <= q.shOut[7];
            serialOutEn <= q.isRead & ~q.first;
        end
    end

endmodule

module gyps_core #(
    parameter int unsigned MS_CYCLES = `GYPS_CLK_KHZ * `GYPS_TICK_MS
) (
    input  wire logic                    clock,
    input  wire logic                    reset,
    input  wire logic                    linkClk,
    input  wire logic                    chipSelectN,
    input  wire logic                    serialIn,
    input  wire logic                    extraIrqPinA,
    input  wire logic                    extraIrqPinB,
    input  wire logic                    secondaryDataOutPin,
    input  wire logic                    sampleValid,
    input  wire gyps_pkg::gyps_rate_type rateFiltered,
    input  wire gyps_pkg::gyps_rate_type rateUnfiltered,
    output logic                         serialOut,
    output logic                         serialOutEn,
    output logic                         senseOn,
    output logic                         driveOn,
    output logic                         acquireOn,
    output logic [3:0]                   irqPinConfig,
    output logic [2:0]                   interfaceConfig
);
    import gyps_pkg::*;

    gyps_state_type q;
    gyps_state_type d;
    gyps_xfer_type  xfer;
    gyps_mode_type  nm;
    logic           wrEv;
    logic           rdEv;
    logic           softRst;
    logic           cfgOk;
    logic           wakeHit;
    logic           tick;
    logic           tout;
    logic [5:0]     dwell;
    logic [6:0]     rel;
    logic [1:0]     wsel;

    function automatic logic [5:0] dwellMs(input logic [63:0] tbl, input logic [2:0] c);
        dwellMs = tbl[{c, 3'h0} +: 6];
    endfunction

    // ------------------------------------------------------------------
    // Serial link
    // ------------------------------------------------------------------
    gyps_link link (
        .linkClk     (linkClk),
        .reset       (reset),
        .chipSelectN (chipSelectN),
        .serialIn    (serialIn),
        .regImage    (q.img),
        .serialOut   (serialOut),
        .serialOutEn (serialOutEn),
        .xfer        (xfer)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d       = q;
        nm      = GYPS_NORMAL;
        wsel    = 2'h0;
        d.csbS  = {q.csbS[0], chipSelectN};
        d.wrS   = {q.wrS[1:0], xfer.wrTog};
        d.rdS   = {q.rdS[1:0], xfer.rdTog};
        d.pinA  = {q.pinA[1:0], extraIrqPinA};
        d.pinB  = {q.pinB[1:0], extraIrqPinB};
        d.pinC  = {q.pinC[1:0], secondaryDataOutPin};
        wrEv    = q.wrS[1] ^ q.wrS[2];
        rdEv    = q.rdS[1] ^ q.rdS[2];
        rel     = xfer.rdAddr - `GYPS_ADR_RATE0;
        softRst = wrEv && (xfer.wrAddr == `GYPS_ADR_SRST);
        cfgOk   = (q.mode != GYPS_LOWEST) && (q.mode != GYPS_AOFF);
        unique case (q.img.psc[`GYPS_PSC_WAKE +: 2])
            2'h0: wakeHit = 1'b0;
            2'h1: wakeHit = q.pinA[1] & ~q.pinA[2];
            2'h2: wakeHit = q.pinB[1] & ~q.pinB[2];
            2'h3: wakeHit = q.pinC[1] & ~q.pinC[2] & q.img.ifc[`GYPS_IF_3W];
        endcase

        // Register writes, filtered by power mode
        if (wrEv) begin
            case (xfer.wrAddr)
                `GYPS_ADR_BW: begin
                    if (cfgOk) d.img.bw = xfer.wrData & `GYPS_BW_MASK;
                end
                `GYPS_ADR_PMC: begin
                    if (q.mode == GYPS_LOWEST) begin
                        d.img.pmc[`GYPS_PMC_LOW] = xfer.wrData[`GYPS_PMC_LOW];
                    end else begin
                        d.img.pmc = xfer.wrData & `GYPS_PMC_MASK;
                    end
                end
                `GYPS_ADR_PSC: begin
                    if (cfgOk) d.img.psc = xfer.wrData & `GYPS_PSC_MASK;
                end
                `GYPS_ADR_RO: begin
                    if (cfgOk) d.img.ro = xfer.wrData & `GYPS_RO_MASK;
                end
                `GYPS_ADR_IE: begin
                    if (q.mode != GYPS_AOFF) d.img.ie = xfer.wrData & `GYPS_IE_MASK;
                end
                `GYPS_ADR_IF: begin
                    if (q.mode != GYPS_AOFF) d.img.ifc = xfer.wrData & `GYPS_IF_MASK;
                end
                default: ;
            endcase
        end

        if (softRst) begin
            d.img.bw  = `GYPS_BW_RST;
            d.img.pmc = `GYPS_PMC_RST;
            d.img.psc = `GYPS_PSC_RST;
            d.img.ro  = `GYPS_RO_RST;
            d.img.ie  = `GYPS_IE_RST;
            d.img.ifc = `GYPS_IF_RST;
            d.lock    = 3'h0;
        end

        if (wakeHit && !cfgOk) begin
            d.img.pmc[`GYPS_PMC_LOW]  = 1'b0;
            d.img.pmc[`GYPS_PMC_AOFF] = 1'b0;
        end

        // Lowest power wipes configuration; wake source kept so waking works
        if (d.img.pmc[`GYPS_PMC_LOW]) begin
            wsel                            = d.img.psc[`GYPS_PSC_WAKE +: 2];
            d.img.bw                        = `GYPS_BW_RST;
            d.img.pmc                       = `GYPS_PMC_RST;
            d.img.pmc[`GYPS_PMC_LOW]        = 1'b1;
            d.img.psc                       = `GYPS_PSC_RST;
            d.img.psc[`GYPS_PSC_WAKE +: 2]  = wsel;
            d.img.ro                        = `GYPS_RO_RST;
            d.lock                          = 3'h0;
        end

        // Duty-cycle dwell timer
        if (q.mode == GYPS_CYC_SLEEP) begin
            dwell = dwellMs(`GYPS_SLEEP_MS, q.img.pmc[`GYPS_PMC_SLP +: 3]);
        end else begin
            dwell = dwellMs(`GYPS_AWAKE_MS, q.img.psc[`GYPS_PSC_AWK +: 3]);
        end
        tick    = (q.pre == 16'(MS_CYCLES - 1));
        tout    = tick && (q.msCnt == dwell - 6'h01);
        d.pre   = tick ? 16'h0000 : q.pre + 16'h0001;
        d.msCnt = tick ? q.msCnt + 6'h01 : q.msCnt;

        if (d.img.pmc[`GYPS_PMC_LOW]) begin
            nm = GYPS_LOWEST;
        end else if (d.img.pmc[`GYPS_PMC_AOFF]) begin
            nm = d.img.psc[`GYPS_PSC_FAST] ? GYPS_FAST : GYPS_AOFF;
        end else if (d.img.psc[`GYPS_PSC_PSEN]) begin
            nm = (q.mode == GYPS_CYC_SLEEP) ? GYPS_CYC_SLEEP : GYPS_CYC_AWAKE;
            if (tout && q.mode == GYPS_CYC_AWAKE) nm = GYPS_CYC_SLEEP;
            if (tout && q.mode == GYPS_CYC_SLEEP) nm = GYPS_CYC_AWAKE;
        end
        if (nm != q.mode) begin
            d.pre   = 16'h0000;
            d.msCnt = 6'h00;
        end
        d.mode = nm;

        unique case (nm)
            GYPS_NORMAL, GYPS_CYC_AWAKE: begin
                d.senseOn = 1'b1;
                d.driveOn = 1'b1;
            end
            GYPS_FAST, GYPS_CYC_SLEEP: begin
                d.senseOn = 1'b0;
                d.driveOn = 1'b1;
            end
            GYPS_LOWEST, GYPS_AOFF: begin
                d.senseOn = 1'b0;
                d.driveOn = 1'b0;
            end
        endcase
        d.acquireOn = d.senseOn;

        // Rate capture and readout image
        if (q.acquireOn && sampleValid) begin
            d.live = q.img.ro[`GYPS_RO_UNF] ? rateUnfiltered : rateFiltered;
        end
        if (rdEv && rel < `GYPS_RATE_BYTES) begin
            d.lock[rel[2:1]] = ~rel[0] & ~q.img.ro[`GYPS_RO_SHD];
        end
        if (q.img.ro[`GYPS_RO_SHD]) d.lock = 3'h0;
        for (int i = 0; i < 3; i++) begin
            if (q.csbS[1]) begin
                d.img.rate[i][7:0] = q.live[i][7:0];
                if (!q.lock[i]) d.img.rate[i][15:8] = q.live[i][15:8];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            q           <= '0;
            q.mode      <= GYPS_NORMAL;
            q.img.bw    <= `GYPS_BW_RST;
            q.img.pmc   <= `GYPS_PMC_RST;
            q.img.psc   <= `GYPS_PSC_RST;
            q.img.ro    <= `GYPS_RO_RST;
            q.img.ie    <= `GYPS_IE_RST;
            q.img.ifc   <= `GYPS_IF_RST;
            q.csbS      <= 2'h3;
            q.senseOn   <= 1'b1;
            q.driveOn   <= 1'b1;
            q.acquireOn <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign senseOn         = q.senseOn;
    assign driveOn         = q.driveOn;
    assign acquireOn       = q.acquireOn;
    assign irqPinConfig    = q.img.ie[3:0];
    assign interfaceConfig = q.img.ifc[2:0];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence lowIfWrite;
        q.mode == GYPS_LOWEST && wrEv && xfer.wrAddr == `GYPS_ADR_IF;
    endsequence

    sequence lowIeWrite;
        q.mode == GYPS_LOWEST && wrEv && xfer.wrAddr == `GYPS_ADR_IE;
    endsequence

    normal_at_start_a: assert property ($fell(reset) |-> q.mode == GYPS_NORMAL && q.acquireOn)
        else $error("not in normal mode after reset");
    lowest_tracks_req_a: assert property (q.img.pmc[`GYPS_PMC_LOW] == (q.mode == GYPS_LOWEST))
        else $error("lowest mode and request bit disagree");
    lowest_cfg_lost_a: assert property (q.mode == GYPS_LOWEST |-> !q.senseOn && !q.acquireOn
        && q.img.bw == `GYPS_BW_RST && q.img.ro == `GYPS_RO_RST)
        else $error("lowest mode still senses or keeps config");
    lowest_if_write_a: assert property (lowIfWrite |=>
        q.img.ifc == ($past(xfer.wrData) & `GYPS_IF_MASK))
        else $error("interface bits not writable in lowest mode");
    lowest_ie_write_a: assert property (lowIeWrite |=>
        q.img.ie == ($past(xfer.wrData) & `GYPS_IE_MASK))
        else $error("pin config not writable in lowest mode");
    softreset_normal_a: assert property (wrEv && xfer.wrAddr == `GYPS_ADR_SRST |=> q.mode == GYPS_NORMAL)
        else $error("soft reset did not restore normal mode");
    aoff_holds_data_a: assert property (q.mode == GYPS_AOFF |=> $stable(q.live))
        else $error("rate data changed in analog-off mode");
    aoff_blocks_cfg_a: assert property (q.mode == GYPS_AOFF && wrEv && xfer.wrAddr == `GYPS_ADR_BW
        |=> $stable(q.img.bw))
        else $error("config write accepted in analog-off mode");
    aoff_entry_a: assert property ($rose(q.img.pmc[`GYPS_PMC_AOFF]) && !q.img.pmc[`GYPS_PMC_LOW]
        && !q.img.psc[`GYPS_PSC_FAST] |-> q.mode == GYPS_AOFF && !q.driveOn)
        else $error("analog-off request not honoured");
    wake_exit_a: assert property (wakeHit && q.mode == GYPS_AOFF
        |=> q.mode != GYPS_AOFF && q.mode != GYPS_LOWEST)
        else $error("wake pin did not leave analog-off mode");
    fast_mode_a: assert property (q.img.pmc[`GYPS_PMC_AOFF] && !q.img.pmc[`GYPS_PMC_LOW]
        && q.img.psc[`GYPS_PSC_FAST] |-> q.mode == GYPS_FAST && q.driveOn && !q.senseOn)
        else $error("fast-wake mode not entered or wrong power");
    cycle_order_a: assert property ($changed(q.mode) && q.mode == GYPS_CYC_SLEEP
        |-> $past(q.mode) == GYPS_CYC_AWAKE)
        else $error("duty sleep entered from wrong phase");
    msb_lock_a: assert property (q.lock[0] |=> $stable(q.img.rate[0][15:8]))
        else $error("locked upper byte changed");
    burst_freeze_a: assert property (!q.csbS[1] && !$past(q.csbS[1]) |-> $stable(q.img.rate))
        else $error("rate image changed during a frame");
    unfilt_select_a: assert property (q.acquireOn && sampleValid && q.img.ro[`GYPS_RO_UNF]
        |=> q.live == $past(rateUnfiltered))
        else $error("unfiltered data not selected");

endmodule

/* core/gyps_params.svh */
`ifndef GYPS_PARAMS_SVH
`define GYPS_PARAMS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define GYPS_ADR_RATE0   7'h02
`define GYPS_ADR_RATE5   7'h07
`define GYPS_ADR_BW      7'h10
`define GYPS_ADR_PMC     7'h11
`define GYPS_ADR_PSC     7'h12
`define GYPS_ADR_RO      7'h13
`define GYPS_ADR_SRST    7'h14
`define GYPS_ADR_IE      7'h20
`define GYPS_ADR_IF      7'h34
`define GYPS_ADR_BUF     7'h3F
`define GYPS_RATE_BYTES  7'h06

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define GYPS_PMC_AOFF    7
`define GYPS_PMC_LOW     5
`define GYPS_PMC_SLP     1
`define GYPS_PSC_FAST    7
`define GYPS_PSC_PSEN    6
`define GYPS_PSC_WAKE    4
`define GYPS_PSC_AWK     0
`define GYPS_RO_UNF      7
`define GYPS_RO_SHD      6
`define GYPS_IF_3W       0

// ----------------------------------------------------------------------
// Writable bits and reset values
// ----------------------------------------------------------------------
`define GYPS_BW_MASK     8'h0F
`define GYPS_PMC_MASK    8'hAE
`define GYPS_PSC_MASK    8'hF7
`define GYPS_RO_MASK     8'hC0
`define GYPS_IE_MASK     8'h0F
`define GYPS_IF_MASK     8'h07
`define GYPS_BW_RST      8'h00
`define GYPS_PMC_RST     8'h00
`define GYPS_PSC_RST     8'h00
`define GYPS_RO_RST      8'h00
`define GYPS_IE_RST      8'h00
`define GYPS_IF_RST      8'h00

// ----------------------------------------------------------------------
// Timing: dwell tables in ms, one byte per code, code 0 lowest
// ----------------------------------------------------------------------
`define GYPS_CLK_KHZ     50000
`define GYPS_TICK_MS     1
`define GYPS_SLEEP_MS    64'h14_12_0F_0A_08_05_04_02
`define GYPS_AWAKE_MS    64'h28_14_0F_0A_08_05_04_04

`endif

/* core/gyps_pkg.sv */
package gyps_pkg;

    typedef enum logic [5:0] {
        GYPS_NORMAL    = 6'h01,
        GYPS_LOWEST    = 6'h02,
        GYPS_AOFF      = 6'h04,
        GYPS_FAST      = 6'h08,
        GYPS_CYC_AWAKE = 6'h10,
        GYPS_CYC_SLEEP = 6'h20
    } gyps_mode_type;

    typedef logic [2:0][15:0] gyps_rate_type;

    typedef struct packed {
        gyps_rate_type rate;
        logic [7:0]    bw;
        logic [7:0]    pmc;
        logic [7:0]    psc;
        logic [7:0]    ro;
        logic [7:0]    ie;
        logic [7:0]    ifc;
    } gyps_image_type;

    typedef struct packed {
        logic [6:0] wrAddr;
        logic [7:0] wrData;
        logic       wrTog;
        logic [6:0] rdAddr;
        logic       rdTog;
    } gyps_xfer_type;

    typedef struct packed {
        logic       first;
        logic       isRead;
        logic [2:0] bitCnt;
        logic [6:0] addr;
        logic [6:0] shIn;
        logic [7:0] shOut;
    } gyps_link_type;

    typedef struct packed {
        gyps_mode_type  mode;
        gyps_image_type img;
        gyps_rate_type  live;
        logic [2:0]     lock;
        logic [1:0]     csbS;
        logic [2:0]     wrS;
        logic [2:0]     rdS;
        logic [2:0]     pinA;
        logic [2:0]     pinB;
        logic [2:0]     pinC;
        logic [15:0]    pre;
        logic [5:0]     msCnt;
        logic           senseOn;
        logic           driveOn;
        logic           acquireOn;
    } gyps_state_type;

endpackage

/* verification/gyps_core_tb.sv */
`timescale 1ns/100ps
module gyps_core_tb;
    import gyps_pkg::*;
    localparam int MS = 20;
    logic          clock = 1'b0;
    logic          reset = 1'b1;
    logic          sampleValid = 1'b0;
    logic [2:0]    pins = 3'h0;
    logic          linkClk, chipSelectN, serialIn, serialOut, serialOutEn, senseOn, driveOn, acquireOn;
    logic [3:0]    irqPinConfig;
    logic [2:0]    interfaceConfig;
    gyps_rate_type rateF = '0;
    gyps_rate_type rateU = '0;
    gyps_rate_type ex;
    int            nMismatch = 0;
    int            nChecks = 0;
    int            cyc = 0;
    int            t;
    logic [31:0]   seed = 32'h0000_48BA;
    logic [31:0]   r;
    int            sleepTab [8] = '{2, 4, 5, 8, 10, 15, 18, 20};
    int            awakeTab [8] = '{4, 4, 5, 8, 10, 15, 20, 40};
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin nMismatch++; $display("CHECK FAILED %0t: %h vs %h", $time, g, e); end end

    gyps_core #(.MS_CYCLES(MS)) gyps_core_inst (.clock(clock), .reset(reset), .linkClk(linkClk),
        .chipSelectN(chipSelectN), .serialIn(serialIn), .extraIrqPinA(pins[0]), .extraIrqPinB(pins[1]),
        .secondaryDataOutPin(pins[2]), .sampleValid(sampleValid), .rateFiltered(rateF),
        .rateUnfiltered(rateU), .serialOut(serialOut), .serialOutEn(serialOutEn), .senseOn(senseOn),
        .driveOn(driveOn), .acquireOn(acquireOn), .irqPinConfig(irqPinConfig),
        .interfaceConfig(interfaceConfig));
    // Undriven data line shows the inverse, so a read outside the data phase fails
    gyps_host gyps_host_inst (.linkClk(linkClk), .chipSelectN(chipSelectN), .serialIn(serialIn),
        .serialOut(serialOutEn ? serialOut : ~serialOut));

    always #10 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 60000) begin
            nMismatch++;
            stopTest();
        end
    end

    // ------------------------------
    // Helpers
    // ------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int dwell(input bit sleep, input logic [2:0] c);
        return (sleep ? sleepTab[c] : awakeTab[c]) * MS;
    endfunction
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        gyps_host_inst.frame({1'b0, a}, d, 1);
    endtask
    task automatic rd(input logic [6:0] a, input int n);
        gyps_host_inst.frame({1'b1, a}, 8'h00, n);
    endtask
    task automatic sample();
        @(negedge clock);
        rateF = 48'({rnd(), rnd()});
        rateU = 48'({rnd(), rnd()});
        sampleValid = 1'b1;
        @(negedge clock);
        sampleValid = 1'b0;
        repeat (4) @(negedge clock);
    endtask
    task automatic waitSense(input logic v);
        t = 0;
        while (senseOn !== v && t < 3000) begin
            @(negedge clock);
            t++;
        end
        `CHK(senseOn, v)
    endtask
    task automatic stopTest();
        if (nMismatch == 0 && nChecks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (2) @(negedge clock);
        reset = 1'b0;
        repeat (2) @(negedge clock);
        `CHK({senseOn, driveOn, acquireOn}, 3'b111)
        sample();
        ex = rateF;
        fork
            rd(7'h02, 6);
            begin #300; sample(); end
        join
        for (int i = 0; i < 6; i++) `CHK(gyps_host_inst.rdBuf[i], ex[i/2][8*(i%2) +: 8])
        rd(7'h3E, 3);
        `CHK(gyps_host_inst.rdBuf[2], 8'h00)
        `CHK(gyps_core_inst.xfer.rdAddr, 7'h3F)
        ex = rateF;
        rd(7'h02, 1);
        sample();
        rd(7'h03, 1);
        `CHK(gyps_host_inst.rdBuf[0], ex[0][15:8])
        wr(7'h13, 8'h40);
        rd(7'h02, 1);
        sample();
        rd(7'h03, 1);
        `CHK(gyps_host_inst.rdBuf[0], rateF[0][15:8])
        wr(7'h13, 8'h80);
        sample();
        rd(7'h02, 2);
        `CHK({gyps_host_inst.rdBuf[1], gyps_host_inst.rdBuf[0]}, rateU[0])
        wr(7'h11, 8'h80);
        `CHK({senseOn, driveOn}, 2'b00)
        wr(7'h10, 8'h05);
        ex = rateU;
        sample(); // No acquisition while analog is off
        wr(7'h11, 8'h00);
        waitSense(1'b1);
        rd(7'h10, 1);
        `CHK(gyps_host_inst.rdBuf[0], 8'h00)
        rd(7'h02, 2);
        `CHK({gyps_host_inst.rdBuf[1], gyps_host_inst.rdBuf[0]}, ex[0])
        wr(7'h12, 8'h80);
        wr(7'h11, 8'h80);
        `CHK({senseOn, driveOn}, 2'b01)
        wr(7'h11, 8'h00);
        waitSense(1'b1);
        wr(7'h10, 8'h03);
        wr(7'h11, 8'h20);
        `CHK({senseOn, driveOn}, 2'b00)
        wr(7'h20, 8'h0A);
        wr(7'h34, 8'h06);
        `CHK(irqPinConfig, 4'hA)
        `CHK(interfaceConfig, 3'h6)
        rd(7'h10, 1);
        `CHK(gyps_host_inst.rdBuf[0], 8'h00)
        wr(7'h14, 8'h00);
        waitSense(1'b1);
        rd(7'h10, 1);
        `CHK(gyps_host_inst.rdBuf[0], 8'h00)
        wr(7'h10, 8'h03); // Restore non-default setting
        for (int s = 1; s <= 3; s++) begin
            wr(7'h34, 8'h01);
            wr(7'h12, 8'(s << 4));
            wr(7'h11, (s == 2) ? 8'h80 : 8'h20); // Second pass wakes from analog-off
            `CHK(senseOn, 1'b0)
            @(negedge clock);
            pins[s-1] = 1'b1;
            repeat (8) @(negedge clock);
            pins[s-1] = 1'b0;
            waitSense(1'b1);
        end
        wr(7'h14, 8'h00);
        r = rnd();
        wr(7'h11, {4'h0, r[2:0], 1'b0});
        wr(7'h12, {5'h08, 3'(r[5:3] % 7 + 1)}); // Awake code never 0, bandwidth 0 needs 4 ms
        waitSense(1'b0);
        waitSense(1'b1);
        `CHK(t, dwell(1'b1, r[2:0]))
        waitSense(1'b0);
        `CHK(t, dwell(1'b0, 3'(r[5:3] % 7 + 1)))
        `CHK(driveOn, 1'b1)
        stopTest();
    end
endmodule

/* verification/gyps_host.sv */
`timescale 1ns/100ps
// ------------------------------
// Serial host: idle-high clock
// ------------------------------
module gyps_host (
    output logic      linkClk,
    output logic      chipSelectN,
    output logic      serialIn,
    input  wire logic serialOut
);
    logic [7:0] rdBuf [8];
    initial begin
        linkClk = 1'b1;
        chipSelectN = 1'b1;
        serialIn = 1'b0;
    end
    // Command byte then n data bytes; reads sampled on rising edges
    task automatic frame(input logic [7:0] cmd, input logic [7:0] wd, input int n);
        logic [7:0] sh;
        sh = cmd;
        chipSelectN = 1'b0;
        #100;
        for (int b = 0; b <= n; b++) begin
            for (int i = 7; i >= 0; i--) begin
                linkClk = 1'b0;
                serialIn = sh[i];
                #32;
                linkClk = 1'b1;
                if (b > 0) rdBuf[b-1][i] = serialOut;
                #32;
            end
            sh = wd;
        end
        chipSelectN = 1'b1;
        serialIn = ~serialIn;
        #500; // Gap between frames
    endtask
endmodule
